// [common/pls_defs.svh]
// Constants for the programmable logic slice
`ifndef PLS_DEFS_SVH
`define PLS_DEFS_SVH
`define PLS_LUT_INPUTS   4
`define PLS_LUT_ENTRIES  16
`define PLS_MEM_WORDS    16
`define PLS_MEM_WIDTH    4
`define PLS_MEM_SLICES   3
`define PLS_CNT_RESET    2'h0
`define PLS_MODE_LOGIC   2'h0
`define PLS_MODE_RIPPLE  2'h1
`define PLS_MODE_RAM     2'h2
`define PLS_MODE_ROM     2'h3
`endif

// [common/pls_pkg.sv]
// Types for the programmable logic slice
package pls_pkg;
   typedef enum logic [1:0] {
      PLS_LOGIC  = 2'h0,
      PLS_RIPPLE = 2'h1,
      PLS_RAM    = 2'h2,
      PLS_ROM    = 2'h3
   } pls_mode_t;
   typedef enum logic [2:0] {
      PLS_OP_ADD    = 3'h0,
      PLS_OP_SUB    = 3'h1,
      PLS_OP_ADDSUB = 3'h2,
      PLS_OP_CNTUP  = 3'h3,
      PLS_OP_CNTDN  = 3'h4,
      PLS_OP_CNTUD  = 3'h5,
      PLS_OP_MULT   = 3'h6,
      PLS_OP_CMP    = 3'h7
   } pls_op_t;
   typedef struct packed {
      logic [1:0] a;
      logic [1:0] b;
      logic       carry_in;
      logic       add_not_sub;
      logic       preload;
      logic       clear;
   } pls_ripple_in_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [3:0] wdata;
      logic       wen;
      logic [3:0] raddr;
   } pls_mem_in_t;
endpackage

// [sim/pls_nbr.sv]
// Neighbouring slice model that takes the cascade output into its chain stage
`timescale 1ns/1ps
module pls_nbr (
   input  wire logic i_core_clk,
   input  wire logic i_rst,
   input  wire logic i_cascade,
   output logic      o_chain
);
   // ---------------------------------------------
   // Chain stage
   // ---------------------------------------------
   // Samples like the next slice's first input, so a late cascade shows up here
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_chain <= 1'b0;
      end else begin
         o_chain <= i_cascade;
      end
   end
endmodule

// [sim/programmable_logic_slice_bench.sv]
// Self-checking bench for the programmable logic slice
`timescale 1ns/1ps
module programmable_logic_slice_bench;
   import pls_pkg::*;
   localparam logic [15:0] L0 = 16'h6996;
   localparam logic [15:0] L1 = 16'h8001;
   localparam logic [63:0] MI = 64'h0123456789abcdef;
   logic           clk, rst, dp, fc, sel5, casc, chain, pc;
   logic           lut0, lut1, five_input_lookup, co, carry, gen, prop, ge, ne, le;
   logic [1:0]     sum, cnt;
   logic [3:0]     l0, l1, rd;
   pls_mode_t      md;
   pls_op_t        op;
   pls_ripple_in_t rip;
   pls_mem_in_t    mem;
   int             miscompares = 0, n_checks = 0, cycles = 0;

   pls_slice #(.LUT0_INIT(L0), .LUT1_INIT(L1), .MEM_INIT(MI)) i_dut (
      .i_core_clk(clk), .i_rst(rst), .i_mode(md), .i_op(op), .i_dual_port(dp), .i_fast_carry(fc),
      .i_lut0_in(l0), .i_lut1_in(l1), .i_sel5(sel5), .i_cascade(casc), .i_rip(rip), .i_mem(mem),
      .o_lut0(lut0), .o_lut1(lut1), .o_five_input_lookup(five_input_lookup), .o_cascade(co), .o_sum(sum), .o_carry(carry),
      .o_gen(gen), .o_prop(prop), .o_count(cnt), .o_ge(ge), .o_ne(ne), .o_le(le), .o_rdata(rd));
   pls_nbr i_nbr (.i_core_clk(clk), .i_rst(rst), .i_cascade(co), .o_chain(chain));

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Inputs change at the falling edge, so outputs are read there settled
   task automatic cyc;
      @(negedge clk);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_logic;
      md = PLS_LOGIC;
      for (int i = 0; i < 32; i++) begin
         l0 = i[3:0];
         l1 = ~i[3:0];
         sel5 = i[4];
         casc = i[0];
         pc = co;
         cyc;
         chk("lut0", L0[i[3:0]], lut0);
         chk("lut1", L1[~i[3:0]], lut1);
         chk("five_input_lookup", i[4] ? L1[~i[3:0]] : L0[i[3:0]], five_input_lookup);
         chk("cascade", i[0] ? (i[4] ? L1[~i[3:0]] : L0[i[3:0]]) : L0[i[3:0]], co);
         chk("chain", pc, chain);
         chk("idle", 4'h0, {gen, prop, carry, sum[0]});
      end
      $display("logic test done");
   endtask
   task automatic t_arith;
      logic [1:0] k, bb;
      logic [2:0] r, g3;
      logic       add;
      md = PLS_RIPPLE;
      for (int i = 0; i < 512; i++) begin
         {fc, rip.add_not_sub, k, rip.carry_in, rip.b, rip.a} = i[8:0];
         op = k == 2'h0 ? PLS_OP_ADD : (k == 2'h1 ? PLS_OP_SUB : PLS_OP_ADDSUB);
         add = k == 2'h0 || (k[1] && rip.add_not_sub);
         bb = add ? rip.b : ~rip.b;
         g3 = {1'b0, rip.a} + {1'b0, bb};
         r = g3 + {2'h0, add ? rip.carry_in : ~rip.carry_in};
         cyc;
         chk("sum", r[1:0], sum);
         chk("carry", r[2], carry);
         chk("gen", fc & g3[2], gen);
         if (fc) chk("fast", r[2], gen | (prop & (add ? rip.carry_in : ~rip.carry_in)));
         else chk("prop", 4'h0, prop);
      end
      $display("arith test done");
   endtask
   task automatic t_cmp_mult;
      logic [2:0] r;
      logic       k;
      for (int i = 0; i < 64; i++) begin
         {k, rip.carry_in, rip.b, rip.a} = i[5:0];
         op = k ? PLS_OP_CMP : PLS_OP_MULT;
         r = {1'b0, rip.a & {2{rip.b[0]}}} + {1'b0, rip.b[1], 1'b0} + rip.carry_in;
         cyc;
         if (k) chk("cmp", {1'b0, rip.a >= rip.b, rip.a != rip.b, rip.a <= rip.b}, {1'b0, ge, ne, le});
         else chk("mult", r, {carry, sum});
      end
      $display("compare and multiply test done");
   endtask
   task automatic t_count;
      logic [1:0] p, e;
      op = PLS_OP_CNTUD;
      rip = '0;
      rip.b = 2'h2;
      rip.preload = 1'b1;
      cyc;
      cyc;
      chk("preload", 4'h2, cnt);
      rip.preload = 1'b0;
      // Wraps through 3 and 0 in both directions
      for (int i = 0; i < 24; i++) begin
         op = i < 8 ? PLS_OP_CNTUP : (i < 16 ? PLS_OP_CNTDN : PLS_OP_CNTUD);
         rip.add_not_sub = i[1];
         p = cnt;
         e = (i < 8 || (i >= 16 && i[1])) ? p + 2'h1 : p - 2'h1;
         cyc;
         chk("count", e, cnt);
      end
      rip.clear = 1'b1;
      cyc;
      chk("clear", 4'h0, cnt);
      rip.clear = 1'b0;
      $display("counter test done");
   endtask
   task automatic t_mem;
      logic [3:0] ra, e;
      // Read trails write by one word, so a refused or lost write shows at once
      for (int i = 0; i < 48; i++) begin
         md = i < 16 ? PLS_ROM : PLS_RAM;
         dp = i < 32;
         mem.wen = i < 32;
         mem.addr = i[3:0];
         mem.wdata = ~i[3:0];
         mem.raddr = i[3:0] - 4'h1;
         ra = i < 32 ? mem.raddr : i[3:0];
         e = i < 17 ? MI[4*ra +: 4] : ~ra;
         cyc;
         chk("rdata", e, rd);
         chk("idle", 4'h0, {lut0, five_input_lookup, carry, sum[0]});
      end
      // Single port write, then read back at the same address
      mem.wen = 1'b1;
      mem.addr = 4'h3;
      mem.wdata = 4'h5;
      cyc;
      chk("old word", 4'hc, rd);
      mem.wen = 1'b0;
      cyc;
      chk("new word", 4'h5, rd);
      cyc;
      chk("held word", 4'h5, rd);
      $display("memory test done");
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles > 3000) begin
         miscompares++;
         print_verdict;
      end
   end
   initial begin
      {rst, dp, fc, sel5, casc, l0, l1} = {1'b1, 12'h0};
      md = PLS_LOGIC;
      op = PLS_OP_ADD;
      rip = '0;
      mem = '0;
      repeat (6) cyc;
      chk("reset", 4'h0, {lut0, lut1, co, carry} | rd | cnt);
      rst = 1'b0;
      t_logic;
      t_arith;
      t_cmp_mult;
      t_count;
      t_mem;
      print_verdict;
   end
endmodule

// [src/pls_ctrl_slice.sv]
// Address and write-control slice of a distributed memory group
`timescale 1ns/1ps
`include "pls_defs.svh"
module pls_ctrl_slice
   import pls_pkg::*;
(
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   input  wire pls_mem_in_t i_mem,
   input  wire logic        i_ram_mode,
   input  wire logic        i_dual_port,
   output logic [3:0]       o_waddr,
   output logic [3:0]       o_raddr,
   output logic             o_we
);
   // Single port reads where it writes; dual port has its own read address
   assign o_waddr = i_mem.addr;
   assign o_raddr = i_dual_port ? i_mem.raddr : i_mem.addr;
   // ROM mode has no write path
   assign o_we    = i_ram_mode & i_mem.wen;

   // Write strobe only ever points where the group writes
   a_waddr_track: assert property (@(posedge i_core_clk) disable iff (i_rst)
      o_we |-> i_ram_mode && o_waddr == i_mem.addr)
      else $error("write strobe outside RAM mode");
endmodule

// [src/pls_slice.sv]
// Programmable logic slice: logic, ripple, RAM and ROM modes
`timescale 1ns/1ps
`include "pls_defs.svh"
module pls_slice
   import pls_pkg::*;
#(
   parameter logic [15:0] LUT0_INIT = 16'h0000,
   parameter logic [15:0] LUT1_INIT = 16'h0000,
   parameter logic [63:0] MEM_INIT  = 64'h0
)
(
   input  wire logic           i_core_clk,
   input  wire logic           i_rst,
   input  wire pls_mode_t      i_mode,
   input  wire pls_op_t        i_op,
   input  wire logic           i_dual_port,
   input  wire logic           i_fast_carry,
   input  wire logic [3:0]     i_lut0_in,
   input  wire logic [3:0]     i_lut1_in,
   input  wire logic           i_sel5,
   input  wire logic           i_cascade,
   input  wire pls_ripple_in_t i_rip,
   input  wire pls_mem_in_t    i_mem,
   output logic                o_lut0,
   output logic                o_lut1,
   output logic                o_five_input_lookup,
   output logic                o_cascade,
   output logic [1:0]          o_sum,
   output logic                o_carry,
   output logic                o_gen,
   output logic                o_prop,
   output logic [1:0]          o_count,
   output logic                o_ge,
   output logic                o_ne,
   output logic                o_le,
   output logic [3:0]          o_rdata
);
   // ----------------------------------------
   // Lookup tables
   // ----------------------------------------
   function automatic logic lut_read(input logic [15:0] tbl, input logic [3:0] idx);
      lut_read = tbl[idx];
   endfunction

   wire logic lut0_val = lut_read(LUT0_INIT, i_lut0_in);
   wire logic lut1_val = lut_read(LUT1_INIT, i_lut1_in);
   wire logic five_input_lookup_val = i_sel5 ? lut1_val : lut0_val;
   // Cascade high picks this slice's five-input result, low keeps its LUT0 result
   wire logic casc_val = i_cascade ? five_input_lookup_val : lut0_val;
   wire logic is_logic = (i_mode == PLS_LOGIC);
   wire logic is_rip   = (i_mode == PLS_RIPPLE);
   wire logic is_ram   = (i_mode == PLS_RAM);
   wire logic is_rom   = (i_mode == PLS_ROM);

   // ----------------------------------------
   // Ripple arithmetic
   // ----------------------------------------
   wire logic       do_sub  = (i_op == PLS_OP_SUB) |
                              ((i_op == PLS_OP_ADDSUB) & ~i_rip.add_not_sub);
   wire logic [1:0] b_eff   = do_sub ? ~i_rip.b : i_rip.b;
   wire logic [2:0] arith   = {1'b0, i_rip.a} + {1'b0, b_eff} + {2'h0, i_rip.carry_in ^ do_sub};
   // Multiplier cell: partial product a&b[0] added to incoming a sum
   wire logic [1:0] pprod   = i_rip.a & {2{i_rip.b[0]}};
   wire logic [2:0] mult    = {1'b0, pprod} + {1'b0, i_rip.b[1], 1'b0} + {2'h0, i_rip.carry_in};
   wire logic [2:0] res     = (i_op == PLS_OP_MULT) ? mult : arith;
   wire logic [1:0] gen_bits  = i_rip.a & b_eff;
   wire logic [1:0] prop_bits = i_rip.a ^ b_eff;
   wire logic       gen_val   = gen_bits[1] | (prop_bits[1] & gen_bits[0]);
   wire logic       prop_val  = &prop_bits;

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   logic [1:0] count;
   wire logic  cnt_up = (i_op == PLS_OP_CNTUP) | ((i_op == PLS_OP_CNTUD) & i_rip.add_not_sub);
   wire logic  cnt_dn = (i_op == PLS_OP_CNTDN) | ((i_op == PLS_OP_CNTUD) & ~i_rip.add_not_sub);
   wire logic  cnt_ud = (i_op == PLS_OP_CNTUD);
   // Clear also steers the next value, so the output copy drops at the next clock edge
   wire logic [1:0] next_count =
      (cnt_ud & i_rip.clear)   ? `PLS_CNT_RESET :
      (cnt_ud & i_rip.preload) ? i_rip.b :
      (is_rip & cnt_up)        ? count + 2'h1 :
      (is_rip & cnt_dn)        ? count - 2'h1 : count;
   // Clear is taken asynchronously only for the up/down counter
   wire logic  cnt_clr = i_rst | (cnt_ud & i_rip.clear);

   always_ff @(posedge i_core_clk or posedge cnt_clr) begin
      if (cnt_clr) begin
         count <= `PLS_CNT_RESET;
      end else begin
         count <= next_count;
      end
   end

   // ----------------------------------------
   // Comparator
   // ----------------------------------------
   wire logic ge_val = (i_rip.a >= i_rip.b);
   wire logic ne_val = (i_rip.a != i_rip.b);
   wire logic le_val = (i_rip.a <= i_rip.b);

   // ----------------------------------------
   // Distributed memory, three-slice group
   // ----------------------------------------
   logic [3:0] waddr;
   logic [3:0] raddr;
   logic       we;

   pls_ctrl_slice u_ctrl (
      .i_core_clk  (i_core_clk),
      .i_rst       (i_rst),
      .i_mem       (i_mem),
      .i_ram_mode  (is_ram),
      .i_dual_port (i_dual_port),
      .o_waddr     (waddr),
      .o_raddr     (raddr),
      .o_we        (we)
   );

   // Two storage slices, each lookup two bits of the word
   typedef logic [`PLS_MEM_WIDTH-1:0] pls_mem_arr_t [`PLS_MEM_WORDS];

   function automatic pls_mem_arr_t mem_image(input logic [63:0] img);
      pls_mem_arr_t img_words;
      for (int i = 0; i < `PLS_MEM_WORDS; i++) begin
         img_words[i] = img[i*4 +: 4];
      end
      return img_words;
   endfunction

   // Memory is configuration state, so reset does not wipe it
   pls_mem_arr_t mem = mem_image(MEM_INIT);

   always_ff @(posedge i_core_clk) begin
      if (we) begin
         mem[waddr] <= i_mem.wdata;
      end
   end

   wire logic [3:0] rd_word = mem[raddr];

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   // Outputs are registered: one cycle after inputs, a pipeline trade for timing
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_lut0    <= 1'b0;
         o_lut1    <= 1'b0;
         o_five_input_lookup    <= 1'b0;
         o_cascade <= 1'b0;
         o_sum     <= 2'h0;
         o_carry   <= 1'b0;
         o_gen     <= 1'b0;
         o_prop    <= 1'b0;
         o_count   <= 2'h0;
         o_ge      <= 1'b0;
         o_ne      <= 1'b0;
         o_le      <= 1'b0;
         o_rdata   <= 4'h0;
      end else begin
         o_lut0    <= is_logic & lut0_val;
         o_lut1    <= is_logic & lut1_val;
         o_five_input_lookup    <= is_logic & five_input_lookup_val;
         o_cascade <= is_logic & casc_val;
         o_sum     <= is_rip ? res[1:0] : 2'h0;
         o_carry   <= is_rip & res[2];
         o_gen     <= is_rip & i_fast_carry & gen_val;
         o_prop    <= is_rip & i_fast_carry & prop_val;
         o_count   <= next_count;
         o_ge      <= is_rip & ge_val;
         o_ne      <= is_rip & ne_val;
         o_le      <= is_rip & le_val;
         o_rdata   <= (is_ram | is_rom) ? rd_word : 4'h0;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_five_input_lookup_select: assert property (@(posedge i_core_clk) disable iff (i_rst)
      is_logic |=> o_five_input_lookup == (($past(i_sel5)) ? $past(lut1_val) : $past(lut0_val)))
      else $error("five-input output wrong");
   a_add_result: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (is_rip && i_op == PLS_OP_ADD) |=>
      {o_carry, o_sum} == {1'b0, $past(i_rip.a)} + {1'b0, $past(i_rip.b)} + {2'h0, $past(i_rip.carry_in)})
      else $error("add result wrong");
   a_count_up: assert property (@(posedge i_core_clk) disable iff (cnt_clr)
      (is_rip && i_op == PLS_OP_CNTUP) |=> count == $past(count) + 2'h1)
      else $error("up count wrong");
   a_count_preload: assert property (@(posedge i_core_clk) disable iff (cnt_clr)
      (i_op == PLS_OP_CNTUD && i_rip.preload) |=> count == $past(i_rip.b))
      else $error("preload missed");
   a_cmp_flags: assert property (@(posedge i_core_clk) disable iff (i_rst)
      is_rip |=> (o_ge | o_le) && (o_ne == !(o_ge && o_le)))
      else $error("compare flags inconsistent");
   a_prop_gate: assert property (@(posedge i_core_clk) disable iff (i_rst)
      !i_fast_carry |=> !o_gen && !o_prop)
      else $error("carry signals outside fast mode");
   a_ram_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (is_ram && i_mem.wen && !i_dual_port) ##1 (is_ram && !i_dual_port && i_mem.addr == $past(i_mem.addr))
      |=> o_rdata == $past(i_mem.wdata, 2))
      else $error("written word not read back");
   a_rom_nowrite: assert property (@(posedge i_core_clk) disable iff (i_rst)
      is_rom |-> !we)
      else $error("write in ROM mode");

   // ----------------------------------------
   // Checks: mode gating and lookup outputs
   // ----------------------------------------
   // Idle outputs other than o_count stay low so a neighbour never sees a stale result
   a_logic_quiet: assert property (@(posedge i_core_clk) disable iff (i_rst)
      !is_logic |=> !o_lut0 && !o_lut1 && !o_five_input_lookup && !o_cascade)
      else $error("lookup output outside logic mode");
   a_ripple_quiet: assert property (@(posedge i_core_clk) disable iff (i_rst)
      !is_rip |=> o_sum == 2'h0 && !o_carry && !o_gen && !o_prop && !o_ge && !o_ne && !o_le)
      else $error("ripple output outside ripple mode");
   a_mem_quiet: assert property (@(posedge i_core_clk) disable iff (i_rst)
      !(is_ram || is_rom) |=> o_rdata == 4'h0)
      else $error("read data outside memory modes");
   a_lut_tables: assert property (@(posedge i_core_clk) disable iff (i_rst)
      is_logic |=> o_lut0 == $past(LUT0_INIT[i_lut0_in]) && o_lut1 == $past(LUT1_INIT[i_lut1_in]))
      else $error("lookup table output wrong");
   a_cascade_pick: assert property (@(posedge i_core_clk) disable iff (i_rst)
      is_logic |=> o_cascade == ($past(i_cascade) ? o_five_input_lookup : o_lut0))
      else $error("cascade output wrong");

   // ----------------------------------------
   // Checks: arithmetic
   // ----------------------------------------
   // Carry out high on subtract means no borrow
   a_sub_result: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (is_rip && i_op == PLS_OP_SUB) |=>
      {o_carry, o_sum} == {1'b0, $past(i_rip.a)} + {1'b0, ~$past(i_rip.b)} + {2'h0, ~$past(i_rip.carry_in)})
      else $error("subtract result wrong");
   a_addsub_pick: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (is_rip && i_op == PLS_OP_ADDSUB && !i_rip.add_not_sub) |=>
      {o_carry, o_sum} == {1'b0, $past(i_rip.a)} + {1'b0, ~$past(i_rip.b)} + {2'h0, ~$past(i_rip.carry_in)})
      else $error("dynamic subtract wrong");
   a_mult_cell: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (is_rip && i_op == PLS_OP_MULT) |=>
      {o_carry, o_sum} == {1'b0, $past(i_rip.a) & {2{$past(i_rip.b[0])}}} +
         {1'b0, $past(i_rip.b[1]), 1'b0} + {2'h0, $past(i_rip.carry_in)})
      else $error("multiplier cell wrong");
   a_gen_carry: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (is_rip && i_fast_carry && i_op == PLS_OP_ADD) |=>
      o_carry == (o_gen | (o_prop & $past(i_rip.carry_in))))
      else $error("generate and propagate disagree with carry");
   a_cmp_values: assert property (@(posedge i_core_clk) disable iff (i_rst)
      is_rip |=> o_ne == ($past(i_rip.a) != $past(i_rip.b)))
      else $error("not-equal flag wrong");
   a_cmp_equal: assert property (@(posedge i_core_clk) disable iff (i_rst)
      is_rip |=> (o_ge && o_le) == ($past(i_rip.a) == $past(i_rip.b)))
      else $error("equal operands not flagged");

   // ----------------------------------------
   // Checks: counter
   // ----------------------------------------
   // Async clear disables these, bar the clear check, since it may land between edges
   a_count_down: assert property (@(posedge i_core_clk) disable iff (cnt_clr)
      (is_rip && i_op == PLS_OP_CNTDN) |=> count == $past(count) - 2'h1)
      else $error("down count wrong");
   a_count_updown: assert property (@(posedge i_core_clk) disable iff (cnt_clr)
      (is_rip && i_op == PLS_OP_CNTUD && !i_rip.preload && i_rip.add_not_sub) |=>
      count == $past(count) + 2'h1)
      else $error("up/down count wrong");
   a_count_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (cnt_ud && i_rip.clear) |-> count == 2'h0)
      else $error("clear did not empty the counter");
   a_count_mirror: assert property (@(posedge i_core_clk) disable iff (cnt_clr)
      o_count == count)
      else $error("count output differs from counter");

   // ----------------------------------------
   // Checks: distributed memory
   // ----------------------------------------
   // Reads see the word from before a same-edge write
   a_ram_store: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (is_ram && i_mem.wen) |=> mem[$past(i_mem.addr)] == $past(i_mem.wdata))
      else $error("write did not land");
   a_dual_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
      ((is_ram || is_rom) && i_dual_port) |=> o_rdata == $past(mem[i_mem.raddr]))
      else $error("read port data wrong");
   a_single_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
      ((is_ram || is_rom) && !i_dual_port) |=> o_rdata == $past(mem[i_mem.addr]))
      else $error("single port read wrong");
   a_rom_frozen: assert property (@(posedge i_core_clk) disable iff (i_rst)
      is_rom |=> mem[$past(i_mem.addr)] == $past(mem[i_mem.addr]))
      else $error("ROM contents changed");
endmodule
